// ### output_monitor_pkg.sv
// Constants, types and timing for the displacement output and limit monitor.
// Assumes one 125 MHz clock; measured values and thresholds are signed integers in sensor units.
// Operation
// - Displacement output spans 4..20 mA or 0..10 V per selected output type.
// - Full swing of 16 mA or 10 V equals the whole measuring range.
// - Two points set output start and end; linear in between.
// - Reversed characteristic maps start point high and end point low.
// - Each auxiliary output is either a temperature or a limit output.
// - Temperature mode scales chosen temperature onto 0..5 V between range ends.
// - Limit mode checks each result against thresholds A and B.
// - Limit types are relative, peak-to-peak and dynamic, chosen per output.
// - Relative type measures thresholds from the configured reference value.
// - Peak-to-peak type compares block-wise peak-to-peak value against thresholds.
// - Output stays passive while infringement is shorter than the delay time.
package output_monitor_pkg;
	localparam int DW = 16;
	localparam int VW = 18;
	localparam int OW = 16;
	localparam int TW = 20;

	localparam logic [OW-1:0] CUR_START_UA = 16'h0fa0;
	localparam logic [OW-1:0] CUR_SPAN_UA = 16'h3e80;
	localparam logic [OW-1:0] VOLT_SPAN_MV = 16'h2710;
	localparam logic [OW-1:0] TEMP_SPAN_MV = 16'h1388;

	localparam int CLK_FREQ_HZ = 125_000_000;
	localparam int US_PER_SECOND = 1_000_000;
	localparam int TICK_CYCLES = CLK_FREQ_HZ / US_PER_SECOND;
	localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

	typedef enum logic [2:0] {
		LIM_RELATIVE = 3'h1,
		LIM_PEAK = 3'h2,
		LIM_DYNAMIC = 3'h4
	} limit_type_e;

	typedef enum logic [2:0] {
		ST_PASSIVE = 3'h1,
		ST_DELAY = 3'h2,
		ST_ACTIVE = 3'h4
	} limit_state_e;
endpackage : output_monitor_pkg

// ### limit_if.sv
// Per-channel link between the output stage and one limit monitor.
// Assumes the output stage drives all inputs synchronous to clk.
interface limit_if;
	logic us_tick;
	logic sample_valid;
	logic signed [output_monitor_pkg::VW-1:0] value;
	output_monitor_pkg::limit_type_e ltype;
	logic signed [output_monitor_pkg::DW-1:0] thr_a;
	logic signed [output_monitor_pkg::DW-1:0] thr_b;
	logic [output_monitor_pkg::DW-1:0] hysteresis;
	logic [output_monitor_pkg::TW-1:0] delay_us;
	logic [output_monitor_pkg::TW-1:0] hold_us;
	logic [output_monitor_pkg::TW-1:0] p2p_us;
	logic active;

	modport src (output us_tick, sample_valid, value, ltype, thr_a, thr_b, hysteresis,
		delay_us, hold_us, p2p_us, input active);
	modport mon (input us_tick, sample_valid, value, ltype, thr_a, thr_b, hysteresis,
		delay_us, hold_us, p2p_us, output active);
endinterface : limit_if

// ### limit_channel.sv
// One limit monitor: infringement detection, delay and hold qualification.
// Assumes value is already offset for relative and dynamic types.
module limit_channel (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Channel link
	limit_if.mon lif
);
	localparam int VW = output_monitor_pkg::VW;
	localparam int TW = output_monitor_pkg::TW;

	output_monitor_pkg::limit_state_e state_q;
	logic [TW-1:0] cnt_q;
	logic [TW-1:0] blk_q;
	logic blk_first_q;
	logic signed [VW-1:0] max_q, min_q, p2p_q;
	logic p2p_strobe_q;
	logic infr_q;
	logic is_peak;
	logic blk_end;
	logic strobe;
	logic signed [VW-1:0] v, a, b, h;

	assign is_peak = lif.ltype == output_monitor_pkg::LIM_PEAK;
	assign blk_end = lif.us_tick && (blk_q + 1'b1 >= lif.p2p_us);
	assign a = VW'(lif.thr_a);
	assign b = VW'(lif.thr_b);
	assign h = $signed({2'h0, lif.hysteresis});
	assign v = is_peak ? p2p_q : lif.value;
	assign strobe = is_peak ? p2p_strobe_q : lif.sample_valid;
	assign lif.active = state_q == output_monitor_pkg::ST_ACTIVE;

	// Block-wise extremes; a sample in the closing cycle is dropped from both blocks
	always_ff @(posedge clk) begin
		if (rst || !is_peak) begin
			blk_q <= '0;
			blk_first_q <= 1'b1;
			max_q <= '0;
			min_q <= '0;
			p2p_q <= '0;
			p2p_strobe_q <= 1'b0;
		end else begin
			p2p_strobe_q <= blk_end;
			if (blk_end) begin
				blk_q <= '0;
				// A block without samples reports zero, not the last block's extremes
				p2p_q <= blk_first_q ? '0 : max_q - min_q;
				blk_first_q <= 1'b1;
			end else if (lif.us_tick) begin
				blk_q <= blk_q + 1'b1;
			end
			if (lif.sample_valid && !blk_end) begin
				blk_first_q <= 1'b0;
				max_q <= (blk_first_q || lif.value > max_q) ? lif.value : max_q;
				min_q <= (blk_first_q || lif.value < min_q) ? lif.value : min_q;
			end
		end
	end

	// Infringement with hysteresis on the way out
	always_ff @(posedge clk) begin
		if (rst) begin
			infr_q <= 1'b0;
		end else if (strobe) begin
			if (!infr_q) begin
				infr_q <= (v > a) || (v < b);
			end else begin
				infr_q <= (v > a - h) || (v < b + h);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= output_monitor_pkg::ST_PASSIVE;
			cnt_q <= '0;
		end else begin
			unique case (state_q)
				output_monitor_pkg::ST_PASSIVE: begin
					cnt_q <= '0;
					if (infr_q) begin
						state_q <= output_monitor_pkg::ST_DELAY;
					end
				end
				output_monitor_pkg::ST_DELAY: begin
					if (!infr_q) begin
						state_q <= output_monitor_pkg::ST_PASSIVE;
					end else if (cnt_q >= lif.delay_us) begin
						state_q <= output_monitor_pkg::ST_ACTIVE;
						cnt_q <= '0;
					end else if (lif.us_tick) begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				output_monitor_pkg::ST_ACTIVE: begin
					if (lif.us_tick && cnt_q != '1) begin
						cnt_q <= cnt_q + 1'b1;
					end
					if (!infr_q && cnt_q >= lif.hold_us) begin
						state_q <= output_monitor_pkg::ST_PASSIVE;
					end
				end
				default: begin
					state_q <= output_monitor_pkg::ST_PASSIVE;
				end
			endcase
		end
	end
endmodule : limit_channel

// ### displacement_output_limit_monitor.sv
// Output stage: displacement analog output, two auxiliary temperature/limit outputs.
// Assumes configuration ports are static between samples; sample_valid is a pulse.
module displacement_output_limit_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Measurement stream
	input wire logic sample_valid,
	input wire logic signed [output_monitor_pkg::DW-1:0] displacement,
	input wire logic signed [output_monitor_pkg::DW-1:0] sensor_temp,
	input wire logic signed [output_monitor_pkg::DW-1:0] controller_temp,
	// Displacement output setup
	input wire logic out_is_voltage,
	input wire logic signed [output_monitor_pkg::DW-1:0] point_start,
	input wire logic signed [output_monitor_pkg::DW-1:0] point_end,
	input wire logic reverse_char,
	// Auxiliary output setup
	input wire logic [1:0] aux_is_limit,
	input wire logic [1:0] aux_temp_is_ctrl,
	input wire logic signed [output_monitor_pkg::DW-1:0] temp_start [2],
	input wire logic signed [output_monitor_pkg::DW-1:0] temp_end [2],
	// Limit setup
	input output_monitor_pkg::limit_type_e limit_type [2],
	input wire logic signed [output_monitor_pkg::DW-1:0] thr_a [2],
	input wire logic signed [output_monitor_pkg::DW-1:0] thr_b [2],
	input wire logic signed [output_monitor_pkg::DW-1:0] reference [2],
	input wire logic [output_monitor_pkg::DW-1:0] hysteresis [2],
	input wire logic [output_monitor_pkg::TW-1:0] infringement_delay_time [2],
	input wire logic [output_monitor_pkg::TW-1:0] output_hold_time [2],
	input wire logic [output_monitor_pkg::TW-1:0] p2p_block_time [2],
	input wire logic [1:0] negative_logic,
	// Outputs
	output logic [output_monitor_pkg::OW-1:0] disp_out_q,
	output logic [output_monitor_pkg::OW-1:0] aux_out_q [2],
	output logic [1:0] switch_q
);
	localparam int DW = output_monitor_pkg::DW;
	localparam int VW = output_monitor_pkg::VW;
	localparam int OW = output_monitor_pkg::OW;

	// Linear map of x from [s, e] onto [0, span], clamped at both ends
	function automatic logic [OW-1:0] scale(input logic signed [DW-1:0] x, input logic signed [DW-1:0] s,
		input logic signed [DW-1:0] e, input logic [OW-1:0] span);
		logic signed [47:0] xs, ss, es, sp, num, den, q;
		xs = 48'(x);
		ss = 48'(s);
		es = 48'(e);
		sp = $signed({32'h0000_0000, span});
		num = (xs - ss) * sp;
		den = es - ss;
		q = (den == 48'sh0) ? 48'sh0 : num / den;
		if (q < 48'sh0) begin
			return '0;
		end
		if (q > sp) begin
			return span;
		end
		return q[OW-1:0];
	endfunction : scale

	logic [6:0] div_q;
	logic tick_q;
	logic signed [DW-1:0] prev_q;
	logic [OW-1:0] disp_span, disp_lin, disp_d;

	// Microsecond enable for all delay, hold and block timers
	always_ff @(posedge clk) begin
		if (rst || div_q == output_monitor_pkg::TICK_LAST) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= div_q == output_monitor_pkg::TICK_LAST;
		end
	end

	always_comb begin
		disp_span = out_is_voltage ? output_monitor_pkg::VOLT_SPAN_MV : output_monitor_pkg::CUR_SPAN_UA;
		disp_lin = scale(displacement, point_start, point_end, disp_span);
		if (reverse_char) begin
			disp_lin = disp_span - disp_lin;
		end
		disp_d = out_is_voltage ? disp_lin : output_monitor_pkg::CUR_START_UA + disp_lin;
	end

	// Output sits at the low end of the current span until the first sample
	always_ff @(posedge clk) begin
		if (rst) begin
			disp_out_q <= output_monitor_pkg::CUR_START_UA;
		end else if (sample_valid) begin
			disp_out_q <= disp_d;
		end
	end

	// Previous sample, the baseline of the dynamic type
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_q <= '0;
		end else if (sample_valid) begin
			prev_q <= displacement;
		end
	end

	limit_if lif [2] ();

	for (genvar i = 0; i < 2; i++) begin : g_aux
		logic signed [DW-1:0] temp_sel;
		logic signed [VW-1:0] val;

		assign temp_sel = aux_temp_is_ctrl[i] ? controller_temp : sensor_temp;

		always_comb begin
			unique case (limit_type[i])
				output_monitor_pkg::LIM_RELATIVE: val = VW'(displacement) - VW'(reference[i]);
				output_monitor_pkg::LIM_DYNAMIC: val = VW'(displacement) - VW'(prev_q);
				output_monitor_pkg::LIM_PEAK: val = VW'(displacement);
				default: val = '0;
			endcase
		end

		assign lif[i].us_tick = tick_q;
		assign lif[i].sample_valid = sample_valid && aux_is_limit[i];
		assign lif[i].value = val;
		assign lif[i].ltype = limit_type[i];
		assign lif[i].thr_a = thr_a[i];
		assign lif[i].thr_b = thr_b[i];
		assign lif[i].hysteresis = hysteresis[i];
		assign lif[i].delay_us = infringement_delay_time[i];
		assign lif[i].hold_us = output_hold_time[i];
		assign lif[i].p2p_us = p2p_block_time[i];

		// Monitor held in reset while the output works as temperature output
		limit_channel u_limit (
			.clk(clk),
			.rst(rst || !aux_is_limit[i]),
			.lif(lif[i])
		);

		always_ff @(posedge clk) begin
			if (rst) begin
				aux_out_q[i] <= '0;
			end else if (aux_is_limit[i]) begin
				aux_out_q[i] <= '0;
			end else begin
				aux_out_q[i] <= scale(temp_sel, temp_start[i], temp_end[i], output_monitor_pkg::TEMP_SPAN_MV);
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				switch_q[i] <= 1'b0;
			end else if (aux_is_limit[i]) begin
				switch_q[i] <= lif[i].active ^ negative_logic[i];
			end else begin
				switch_q[i] <= negative_logic[i];
			end
		end
	end
endmodule : displacement_output_limit_monitor

// ### dolm_assertions.sv
// Port-level checker for the output stage.
// Assumes the single clk domain with synchronous rst.
module dolm_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire logic sample_valid,
	input wire logic out_is_voltage,
	input wire logic [1:0] aux_is_limit,
	input wire logic [1:0] negative_logic,
	input wire logic [output_monitor_pkg::OW-1:0] disp_out_q,
	input wire logic [output_monitor_pkg::OW-1:0] aux_out_q [2],
	input wire logic [1:0] switch_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_rst_val;
		$past(rst) |-> disp_out_q == 16'h0fa0 && aux_out_q[0] == 16'h0000;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("output not at low end after reset");
	property p_cur_span;
		$past(sample_valid) && !$past(out_is_voltage) |-> disp_out_q >= 16'h0fa0 && disp_out_q <= 16'h4e20;
	endproperty
	a_cur_span: assert property (p_cur_span) else $error("current output out of span");
	property p_volt_span;
		$past(sample_valid) && $past(out_is_voltage) |-> disp_out_q <= 16'h2710;
	endproperty
	a_volt_span: assert property (p_volt_span) else $error("voltage output out of span");
	property p_disp_stand;
		!$past(sample_valid) && !$past(rst) |-> $stable(disp_out_q);
	endproperty
	a_disp_stand: assert property (p_disp_stand) else $error("output moved without sample");
	property p_aux_lim_zero;
		aux_is_limit[0] |=> aux_out_q[0] == 16'h0000;
	endproperty
	a_aux_lim_zero: assert property (p_aux_lim_zero) else $error("analog value on limit output");
	property p_temp_span;
		!aux_is_limit[1] |=> aux_out_q[1] <= 16'h1388;
	endproperty
	a_temp_span: assert property (p_temp_span) else $error("temperature output above span");
	property p_temp_switch;
		!aux_is_limit[1] && !$past(aux_is_limit[1]) && !$past(aux_is_limit[1], 2)
			|=> switch_q[1] == $past(negative_logic[1]);
	endproperty
	a_temp_switch: assert property (p_temp_switch) else $error("switch active in temperature mode");
	property p_pol_flip;
		aux_is_limit[0] && $changed(negative_logic[0]) |=> $changed(switch_q[0]);
	endproperty
	a_pol_flip: assert property (p_pol_flip) else $error("switch ignored polarity change");
endmodule : dolm_assertions

bind displacement_output_limit_monitor dolm_assertions chk (.clk(clk), .rst(rst), .sample_valid(sample_valid),
	.out_is_voltage(out_is_voltage), .aux_is_limit(aux_is_limit), .negative_logic(negative_logic),
	.disp_out_q(disp_out_q), .aux_out_q(aux_out_q), .switch_q(switch_q));

// ### machine_input.sv
// Machine controller switching input, behavioural.
// Assumes it knows the polarity configured on each line.
module machine_input (
	// Clock
	input wire logic clk,
	// Lines from the device
	input wire logic [1:0] switch_q,
	input wire logic [1:0] negative_logic,
	// Decoded limit state
	output logic [1:0] seen
);
	timeunit 1ns;
	timeprecision 1ps;
	// Latched on the edge like an input card; one cycle late
	always_ff @(posedge clk) begin
		seen <= switch_q ^ negative_logic;
	end
endmodule : machine_input

// ### tb_top.sv
// Self-checking bench for the output stage and limit monitors.
// Assumes 125 MHz clk; time settings kept to a few microseconds.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int US = 125;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sample_valid = 1'b0;
	logic signed [15:0] displacement = 16'sh0000;
	logic signed [15:0] sensor_temp = 16'sh0000;
	logic signed [15:0] controller_temp = 16'sh0000;
	logic out_is_voltage = 1'b0;
	logic reverse_char = 1'b0;
	logic signed [15:0] p_start = 16'sh0000;
	logic [1:0] aux_is_limit = 2'b01;
	logic [1:0] aux_temp_is_ctrl = 2'b00;
	logic signed [15:0] temp_start [2] = '{16'sh0000, 16'sh0000};
	logic signed [15:0] temp_end [2] = '{16'sh0064, 16'sh0064};
	output_monitor_pkg::limit_type_e limit_type [2] = '{output_monitor_pkg::LIM_RELATIVE, output_monitor_pkg::LIM_PEAK};
	output_monitor_pkg::limit_type_e tl [3] = '{output_monitor_pkg::LIM_RELATIVE, output_monitor_pkg::LIM_PEAK,
		output_monitor_pkg::LIM_DYNAMIC};
	logic signed [15:0] thr_a [2] = '{16'sh0064, 16'sh0064};
	logic signed [15:0] thr_b [2] = '{-16'sh0064, -16'sh0064};
	logic signed [15:0] reference [2] = '{16'sh0000, 16'sh0000};
	logic [15:0] hysteresis [2] = '{16'h000a, 16'h000a};
	logic [19:0] delay_t [2] = '{20'h00003, 20'h00003};
	logic [19:0] hold_t [2] = '{20'h00014, 20'h00014};
	logic [19:0] p2p_t [2] = '{20'h00002, 20'h00002};
	logic [1:0] negative_logic = 2'b10;
	logic [15:0] disp_out_q;
	logic [15:0] aux_out_q [2];
	logic [1:0] switch_q;
	logic [1:0] seen;
	logic sv_seen = 1'b0;
	logic [15:0] exp_d;
	logic [15:0] expq [$];
	logic [31:0] lfsr_q = 32'hcfbf;
	int fails = 0;
	int samples_checked = 0;

	always #4 clk = ~clk;

	displacement_output_limit_monitor uut (.clk(clk), .rst(rst), .sample_valid(sample_valid),
		.displacement(displacement), .sensor_temp(sensor_temp), .controller_temp(controller_temp),
		.out_is_voltage(out_is_voltage), .point_start(p_start), .point_end(p_start + 16'sh03e8),
		.reverse_char(reverse_char), .aux_is_limit(aux_is_limit), .aux_temp_is_ctrl(aux_temp_is_ctrl),
		.temp_start(temp_start), .temp_end(temp_end), .limit_type(limit_type), .thr_a(thr_a), .thr_b(thr_b),
		.reference(reference), .hysteresis(hysteresis), .infringement_delay_time(delay_t),
		.output_hold_time(hold_t), .p2p_block_time(p2p_t), .negative_logic(negative_logic),
		.disp_out_q(disp_out_q), .aux_out_q(aux_out_q), .switch_q(switch_q));
	machine_input far (.clk(clk), .switch_q(switch_q), .negative_logic(negative_logic), .seen(seen));

	task automatic check(string name, logic [15:0] e, logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, e, s);
		end
	endtask : check
	// Looks between edges, then hands back on a rising edge for the next drive
	task automatic lim(logic e);
		@(negedge clk);
		check("limit seen", 16'(e), 16'(seen[0]));
		@(posedge clk);
	endtask : lim
	task automatic final_report();
		if (fails == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	// Points kept 1000 apart keep every expected value exact
	function automatic logic [15:0] exp_disp(int x);
		int f;
		f = x - int'(p_start);
		f = f < 0 ? 0 : (f > 1000 ? 1000 : f);
		if (reverse_char) f = 1000 - f;
		return out_is_voltage ? 16'(10 * f) : 16'(4000 + 16 * f);
	endfunction : exp_disp
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic feed(int x, int n, bit alt);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			sample_valid <= 1'b1;
			displacement <= 16'((alt && i % 2 == 0) ? 0 : x);
			expq.push_back(exp_disp((alt && i % 2 == 0) ? 0 : x));
		end
		@(posedge clk);
		sample_valid <= 1'b0;
	endtask : feed
	task automatic wait_cyc(int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : wait_cyc

	always @(posedge clk) sv_seen <= sample_valid;
	always @(negedge clk) begin
		if (sv_seen) begin
			exp_d = expq.pop_front();
			check("disp_out_q", exp_d, disp_out_q);
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			out_is_voltage <= m[0];
			reverse_char <= m[1];
			p_start <= 16'(100 * m);
			feed(-50, 1, 1'b0);
			feed(2000, 1, 1'b0);
			repeat (8) begin
				lfsr_q = lfsr_next(lfsr_q);
				feed(int'(lfsr_q % 32'd1001), 1, 1'b0);
			end
		end
		out_is_voltage <= 1'b0;
		reverse_char <= 1'b0;
		p_start <= 16'sh0000;
		sensor_temp <= 16'sh0032;
		controller_temp <= 16'sh00c8;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			aux_temp_is_ctrl <= {k[0], 1'b0};
			wait_cyc(4);
			check("aux_out_q1", k ? 16'h1388 : 16'h09c4, aux_out_q[1]);
			check("switch_q1", 16'h0001, 16'(switch_q[1]));
			check("aux_out_q0", 16'h0000, aux_out_q[0]);
		end
		@(posedge clk);
		aux_is_limit <= 2'b10;
		wait_cyc(4);
		check("aux_out_q0", 16'h09c4, aux_out_q[0]);
		check("aux_out_q1", 16'h0000, aux_out_q[1]);
		@(posedge clk);
		aux_is_limit <= 2'b01;
		feed(200, US, 1'b0);
		feed(0, 1, 1'b0);
		wait_cyc(5 * US);
		lim(1'b0);
		feed(200, 6 * US, 1'b0);
		lim(1'b1);
		feed(0, 1, 1'b0);
		wait_cyc(5 * US);
		lim(1'b1);
		wait_cyc(20 * US);
		lim(1'b0);
		feed(200, 30 * US, 1'b0);
		feed(95, 2 * US, 1'b0);
		lim(1'b1);
		negative_logic[0] <= 1'b1;
		wait_cyc(US);
		check("switch_q0", 16'h0000, 16'(switch_q[0]));
		lim(1'b1);
		negative_logic[0] <= 1'b0;
		feed(0, 1, 1'b0);
		wait_cyc(3 * US);
		lim(1'b0);
		delay_t[0] <= 20'h00000;
		hold_t[0] <= 20'h00000;
		for (int t = 0; t < 3; t++) begin
			@(posedge clk);
			limit_type[0] <= tl[t];
			rst <= 1'b1;
			repeat (2) @(posedge clk);
			rst <= 1'b0;
			feed(300, 10 * US, 1'b0);
			wait_cyc(10);
			lim(t == 0);
			feed(300, 10 * US, 1'b1);
			wait_cyc(10);
			lim(1'b1);
		end
		final_report();
	end

	// Whole run is about 17k cycles; this cuts a hang well past that
	initial begin
		#(8 * 60000);
		fails++;
		final_report();
	end
endmodule : tb_top
